//--- hdl/sct_defs.vh
// sct_defs.vh: constants for the sdram command timing block
// assumes: included by bare name from design files under hdl/
`ifndef SCT_DEFS_VH
`define SCT_DEFS_VH

// ----------------------------------------
// command encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SCT_CMD_W 4
`define SCT_CMD_MODE 4'h0
`define SCT_CMD_REFRESH 4'h1
`define SCT_CMD_PRECHARGE 4'h2
`define SCT_CMD_ACTIVE 4'h3
`define SCT_CMD_WRITE 4'h4
`define SCT_CMD_READ 4'h5
`define SCT_CMD_STOP 4'h6
`define SCT_CMD_NOP 4'h7

// ----------------------------------------
// widths
// ----------------------------------------
`define SCT_DATA_W 16
`define SCT_LANES 2
`define SCT_ADDR_W 4
`define SCT_FIFO_DEPTH 4

// ----------------------------------------
// cycle figures
// ----------------------------------------
`define SCT_CLOCK_DISABLE_DELAY 1
`define SCT_CLOCK_ENABLE_DELAY 1
`define SCT_MASK_TO_INPUT_DELAY 0
`define SCT_WRITE_TO_DATA_DELAY 0
`define SCT_MASK_TO_FLOAT_DELAY 2
`define SCT_PRECHARGE_TO_FLOAT_CL3 3
`define SCT_PRECHARGE_TO_FLOAT_CL2 2
`define SCT_COLUMN_TO_COLUMN_GAP 1
`define SCT_MODE_LOAD_GAP 2
`define SCT_WRITE_END_TO_PRECHARGE_GAP 2

// ----------------------------------------
// mode word fields and reset values
// ----------------------------------------
`define SCT_MODE_BL_LSB 0
`define SCT_MODE_BL_MSB 2
`define SCT_MODE_CL_LSB 4
`define SCT_MODE_CL_MSB 6
`define SCT_RST_BURST 3'h2
`define SCT_RST_LATENCY 3'h2

`endif

//--- hdl/sct_fifo.v
// sct_fifo.v: small flip-flop fifo with valid/ready on both sides
// assumes: single clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sct_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // sct_fifo
`default_nettype wire

//--- hdl/sct_core.v
// sct_core.v: device-side command timing of a small sdram array
// assumes: commands, mask and data come from logic on clk; clk_en from a pin
`timescale 1ns/1ps
`default_nettype none
`include "sct_defs.vh"
module sct_core (
  input wire clk,
  input wire rst,
  input wire clk_en,
  input wire [`SCT_CMD_W-1:0] cmd,
  input wire [`SCT_ADDR_W-1:0] col_addr,
  input wire [6:0] mode_word,
  input wire [`SCT_LANES-1:0] data_mask,
  input wire [`SCT_DATA_W-1:0] dq_in,
  output reg [`SCT_DATA_W-1:0] dq_out,
  output reg dq_oe,
  output reg rd_valid,
  input wire rd_ready,
  output reg [`SCT_DATA_W-1:0] rd_data,
  output reg suspended,
  output reg [2:0] column_read_latency
);
  // ----------------------------------------
  // clock enable synchroniser and suspend
  // ----------------------------------------
  reg cke_meta_q;
  reg cke_sync_q;
  reg run_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cke_meta_q <= 1'b1;
      cke_sync_q <= 1'b1;
      run_q <= 1'b1;
    end else begin
      cke_meta_q <= clk_en;
      cke_sync_q <= cke_meta_q;
      // internal clock stops/resumes one period after the sampled level
      run_q <= cke_sync_q;
    end
  end

  // ----------------------------------------
  // mode register
  // ----------------------------------------
  reg [2:0] burst_q;
  reg [2:0] latency_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_q <= `SCT_RST_BURST;
      latency_q <= `SCT_RST_LATENCY;
    end else if (run_q && cmd == `SCT_CMD_MODE) begin
      burst_q <= mode_word[`SCT_MODE_BL_MSB:`SCT_MODE_BL_LSB];
      latency_q <= mode_word[`SCT_MODE_CL_MSB:`SCT_MODE_CL_LSB];
    end
  end

  // ----------------------------------------
  // storage array with per-lane write mask
  // ----------------------------------------
  reg [`SCT_DATA_W-1:0] mem_q [0:(1<<`SCT_ADDR_W)-1];
  reg [`SCT_ADDR_W-1:0] col_q;
  reg [3:0] burst_left_q;
  reg wr_burst_q;
  reg rd_burst_q;
  wire col_cmd = run_q && (cmd == `SCT_CMD_WRITE || cmd == `SCT_CMD_READ);
  wire wr_now = run_q && ((cmd == `SCT_CMD_WRITE) || (wr_burst_q && cmd == `SCT_CMD_NOP));
  wire [`SCT_ADDR_W-1:0] wr_addr = (cmd == `SCT_CMD_WRITE) ? col_addr : col_q;
  wire [3:0] blen = (4'h1 << burst_q[1:0]);
  wire rd_now;
  wire fifo_in_ready;
  genvar g;
  generate
    for (g = 0; g < `SCT_LANES; g = g + 1) begin : lane
      // first word taken on the write command edge, mask on the same edge
      always @(posedge clk) begin
        if (wr_now && !data_mask[g]) begin
          mem_q[wr_addr][g*8+7:g*8] <= dq_in[g*8+7:g*8];
        end
      end
    end
  endgenerate

  // a fresh column command cuts any running burst short
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      col_q <= {`SCT_ADDR_W{1'b0}};
      burst_left_q <= 4'h0;
      wr_burst_q <= 1'b0;
      rd_burst_q <= 1'b0;
    end else if (run_q) begin
      if (col_cmd) begin
        col_q <= col_addr + 1'b1;
        burst_left_q <= blen - 4'h1;
        wr_burst_q <= (cmd == `SCT_CMD_WRITE) && (blen != 4'h1);
        rd_burst_q <= (cmd == `SCT_CMD_READ) && (blen != 4'h1);
      end else if (cmd == `SCT_CMD_STOP || cmd == `SCT_CMD_PRECHARGE) begin
        wr_burst_q <= 1'b0;
        rd_burst_q <= 1'b0;
      end else if (burst_left_q != 4'h0) begin
        col_q <= col_q + 1'b1;
        burst_left_q <= burst_left_q - 4'h1;
        if (burst_left_q == 4'h1) begin
          wr_burst_q <= 1'b0;
          rd_burst_q <= 1'b0;
        end
      end
    end
  end

  // drop read beats issued while the output buffer is full; the burst address keeps advancing
  assign rd_now = run_q && fifo_in_ready && ((cmd == `SCT_CMD_READ) || (rd_burst_q && cmd == `SCT_CMD_NOP));

  // ----------------------------------------
  // read latency pipeline, index 0 is newest
  // ----------------------------------------
  reg [3:0] pipe_v_q;
  reg [`SCT_DATA_W-1:0] pipe_d_q [0:3];
  reg [3:0] pch_q;
  reg [1:0] mask_q;
  wire [`SCT_ADDR_W-1:0] rd_addr = (cmd == `SCT_CMD_READ) ? col_addr : col_q;
  wire [1:0] lat_idx = (latency_q == 3'h3) ? 2'h2 : 2'h1;
  wire out_v = pipe_v_q[lat_idx];
  // precharge floats output after latency cycles
  wire pch_cut = (latency_q == 3'h3) ? pch_q[`SCT_PRECHARGE_TO_FLOAT_CL3-1]
                                      : pch_q[`SCT_PRECHARGE_TO_FLOAT_CL2-1];
  // read mask floats output after two cycles
  wire mask_cut = mask_q[`SCT_MASK_TO_FLOAT_DELAY-1];
  integer k;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pipe_v_q <= 4'h0;
      pch_q <= 4'h0;
      mask_q <= 2'h0;
      for (k = 0; k < 4; k = k + 1) begin
        pipe_d_q[k] <= {`SCT_DATA_W{1'b0}};
      end
    end else if (run_q) begin
      pipe_v_q <= {pipe_v_q[2:0], rd_now};
      pipe_d_q[0] <= mem_q[rd_addr];
      for (k = 1; k < 4; k = k + 1) begin
        pipe_d_q[k] <= pipe_d_q[k-1];
      end
      pch_q <= {pch_q[2:0], cmd == `SCT_CMD_PRECHARGE};
      mask_q <= {mask_q[0], data_mask != {`SCT_LANES{1'b0}}};
    end
  end

  // ----------------------------------------
  // output buffer and registered outputs
  // ----------------------------------------
  wire fifo_out_valid;
  wire [`SCT_DATA_W-1:0] fifo_out_data;
  wire fifo_pop = fifo_out_valid && (!rd_valid || rd_ready);
  sct_fifo #(
    .WIDTH(`SCT_DATA_W),
    .DEPTH(`SCT_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(run_q && out_v && !pch_cut && !mask_cut),
    .in_ready(fifo_in_ready),
    .in_data(pipe_d_q[lat_idx]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_out <= {`SCT_DATA_W{1'b0}};
      dq_oe <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= {`SCT_DATA_W{1'b0}};
      suspended <= 1'b0;
      column_read_latency <= `SCT_RST_LATENCY;
    end else begin
      dq_out <= pipe_d_q[lat_idx];
      dq_oe <= run_q && out_v && !pch_cut && !mask_cut;
      if (fifo_pop) begin
        rd_valid <= 1'b1;
        rd_data <= fifo_out_data;
      end else if (rd_ready) begin
        rd_valid <= 1'b0;
      end
      suspended <= !run_q;
      column_read_latency <= latency_q;
    end
  end
endmodule // sct_core
`default_nettype wire

//--- verif/sct_chk.sv
// sct_chk.sv: port timing checker for sct_core
// assumes: bound to sct_core; one clock, async active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "sct_defs.vh"
module sct_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] cmd,
  input wire logic [1:0] data_mask,
  input wire logic dq_oe,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [15:0] rd_data,
  input wire logic suspended,
  input wire logic [2:0] column_read_latency
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // properties
  // ----
  // six samples: the two sync flops and the run flop sit ahead of suspended
  property p_stop; (!clk_en) [*6] |-> suspended; endproperty
  a_stop: assert property (p_stop) else $error("not suspended");
  property p_run; clk_en [*6] |-> !suspended; endproperty
  a_run: assert property (p_run) else $error("not resumed");
  // float lands two cycles on; the registered enable is seen one sample later
  property p_mask; (data_mask != 2'h0 && !suspended) |-> ##3 !dq_oe; endproperty
  a_mask: assert property (p_mask) else $error("mask not floated");
  sequence s_pre; cmd == `SCT_CMD_PRECHARGE && !suspended; endsequence
  property p_pre3; s_pre ##0 column_read_latency == 3'h3 |-> ##4 !dq_oe; endproperty
  a_pre3: assert property (p_pre3) else $error("cl3 float late");
  property p_pre2; s_pre ##0 column_read_latency == 3'h2 |-> ##3 !dq_oe; endproperty
  a_pre2: assert property (p_pre2) else $error("cl2 float late");
  property p_ans; (cmd == `SCT_CMD_READ && data_mask == 2'h0 && !suspended) |-> ##[2:5] dq_oe;
  endproperty
  a_ans: assert property (p_ans) else $error("read data missing");
  property p_hold; (rd_valid && !rd_ready) |=> (rd_valid && $stable(rd_data)); endproperty
  a_hold: assert property (p_hold) else $error("stream word dropped");
  c_susp: cover property (suspended);
  c_pre: cover property (s_pre ##4 !dq_oe);
  c_full: cover property ((rd_valid && !rd_ready) [*4]);
endmodule // sct_chk
bind sct_core sct_chk sct_chk_i (.clk(clk), .rst(rst), .clk_en(clk_en), .cmd(cmd),
  .data_mask(data_mask), .dq_oe(dq_oe), .rd_valid(rd_valid), .rd_ready(rd_ready),
  .rd_data(rd_data), .suspended(suspended), .column_read_latency(column_read_latency));
`default_nettype wire

//--- verif/sct_ctl.sv
// sct_ctl.sv: memory controller model facing sct_core
// assumes: bench calls its tasks; outputs move 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
`include "sct_defs.vh"
module sct_ctl (
  input wire logic clk,
  output logic clk_en,
  output logic [3:0] cmd,
  output logic [3:0] col_addr,
  output logic [6:0] mode_word,
  output logic [1:0] data_mask,
  output logic [15:0] dq_in,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [15:0] rd_data
);
  logic [15:0] got_q [$];
  initial begin
    clk_en = 1'b1;
    cmd = `SCT_CMD_NOP;
    col_addr = 4'h0;
    mode_word = 7'h00;
    data_mask = 2'h0;
    dq_in = 16'h0000;
    rd_ready = 1'b1;
  end
  always @(posedge clk) begin
    if (rd_valid && rd_ready) begin
      got_q.push_back(rd_data);
    end
  end
  // ----
  // command tasks
  // ----
  task automatic issue(input logic [3:0] c, input logic [3:0] a, input logic [1:0] m,
      input logic [15:0] d);
    @(posedge clk);
    #1;
    cmd = c;
    col_addr = a;
    data_mask = m;
    dq_in = d;
  endtask
  // released data bus shows inverted data, never a stale copy
  task automatic idle(input int n);
    repeat (n) issue(`SCT_CMD_NOP, col_addr, 2'h0, ~dq_in);
  endtask
  task automatic rd(input logic [3:0] a);
    issue(`SCT_CMD_READ, a, 2'h0, ~dq_in);
  endtask
  // only clock enable slows the rate; the clock itself never changes
  task automatic set_pins(input logic e, input logic r);
    @(posedge clk);
    #1;
    clk_en = e;
    rd_ready = r;
  endtask
  task automatic load_mode(input logic [6:0] w);
    mode_word = w;
    issue(`SCT_CMD_MODE, 4'h0, 2'h0, ~dq_in);
    idle(2);
  endtask
  task automatic write_burst(input logic [3:0] a, input int n, input logic [1:0] m,
      input logic [15:0] base);
    issue(`SCT_CMD_WRITE, a, m, base);
    for (int i = 1; i < n; i++) begin
      issue(`SCT_CMD_NOP, a, 2'h0, base + 16'(i));
    end
    idle(3);
  endtask
  task automatic power_up;
    idle(20000);
    repeat (2) begin
      issue(`SCT_CMD_REFRESH, 4'h0, 2'h0, ~dq_in);
      idle(14);
    end
    open_rows();
  endtask
  // the clock runs free, so it toggles well over twice in every gap
  task automatic open_rows;
    issue(`SCT_CMD_ACTIVE, 4'h0, 2'h0, ~dq_in);
    idle(4);
    issue(`SCT_CMD_ACTIVE, 4'h1, 2'h0, ~dq_in);
    idle(16);
  endtask
endmodule // sct_ctl
`default_nettype wire

//--- verif/sdram_command_timing_tb_top.sv
// sdram_command_timing_tb_top.sv: self-checking bench for sct_core
// assumes: sct_ctl drives the command side; sct_chk is bound in
`timescale 1ns/1ps
`default_nettype none
`include "sct_defs.vh"
module sdram_command_timing_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire logic clk_en, dq_oe, rd_valid, rd_ready, suspended;
  wire logic [3:0] cmd, col_addr;
  wire logic [6:0] mode_word;
  wire logic [1:0] data_mask;
  wire logic [15:0] dq_in, dq_out, rd_data;
  wire logic [2:0] column_read_latency;
  int n_errors = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  sct_core sct_core_i (.clk(clk), .rst(rst), .clk_en(clk_en), .cmd(cmd),
    .col_addr(col_addr), .mode_word(mode_word), .data_mask(data_mask), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .suspended(suspended), .column_read_latency(column_read_latency));
  sct_ctl ctl (.clk(clk), .clk_en(clk_en), .cmd(cmd), .col_addr(col_addr),
    .mode_word(mode_word), .data_mask(data_mask), .dq_in(dq_in), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));
  // ----
  // scenarios
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic t_mask;
    ctl.load_mode(7'h20);
    ctl.write_burst(4'h3, 1, 2'h0, 16'hA5C3);
    ctl.write_burst(4'h3, 1, 2'h2, 16'h1234);
    ctl.write_burst(4'h2, 1, 2'h0, 16'h5A5A);
    ctl.write_burst(4'h2, 1, 2'h1, 16'hBEEF);
    ctl.got_q.delete();
    ctl.rd(4'h3);
    ctl.rd(4'h2);
    ctl.idle(12);
    check(16'(ctl.got_q.size()), 16'h0002);
    check(ctl.got_q[0], 16'hA534);
    check(ctl.got_q[1], 16'hBE5A);
  endtask
  task automatic t_fifo;
    ctl.load_mode(7'h22);
    ctl.write_burst(4'h4, 4, 2'h0, 16'h1000);
    ctl.got_q.delete();
    ctl.set_pins(1'b1, 1'b0);
    ctl.rd(4'h4);
    ctl.idle(16);
    check(16'({rd_valid, 4'(ctl.got_q.size())}), 16'h0010);
    ctl.set_pins(1'b1, 1'b1);
    ctl.idle(12);
    for (int i = 0; i < 4; i++) begin
      check(ctl.got_q[i], 16'h1000 + 16'(i));
    end
  endtask
  task automatic t_float;
    for (int l = 2; l < 4; l++) begin
      ctl.load_mode({3'(l), 4'h2});
      ctl.got_q.delete();
      ctl.rd(4'h4);
      ctl.idle(3);
      ctl.issue(`SCT_CMD_PRECHARGE, 4'h4, 2'h3, ~ctl.dq_in);
      ctl.idle(10);
      check(16'(dq_oe), 16'h0000);
      check(ctl.got_q[0], 16'h1000);
      // mask with the precharge drops the last beat only at latency three
      check(16'(ctl.got_q.size()), (l == 3) ? 16'h0003 : 16'h0004);
    end
  endtask
  task automatic t_susp;
    ctl.got_q.delete();
    ctl.set_pins(1'b0, 1'b1);
    ctl.idle(8);
    check(16'(suspended), 16'h0001);
    ctl.rd(4'h4);
    ctl.idle(2);
    ctl.set_pins(1'b1, 1'b1);
    ctl.idle(8);
    check(16'({suspended, 4'(ctl.got_q.size())}), 16'h0000);
    ctl.rd(4'h4);
    ctl.idle(10);
    check(ctl.got_q[0], 16'h1000);
  endtask
  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    check(16'({suspended, dq_oe, rd_valid, column_read_latency}), 16'h0002);
    ctl.power_up();
    t_mask();
    t_fifo();
    t_float();
    t_susp();
    complete_run();
  end
  initial begin
    #300000;
    n_errors++;
    complete_run();
  end
endmodule // sdram_command_timing_tb_top
`default_nettype wire
